//--- inc/fpg_regs.vh
`ifndef FPG_REGS_VH
`define FPG_REGS_VH

// bus and byte layout
`define FPG_DATA_W       36
`define FPG_BYTE_W       9
`define FPG_HALF_W       18
`define FPG_PAR_BIT      8

// byte lanes, byte 3 is the most significant
`define FPG_B3_HI        35
`define FPG_B3_LO        27
`define FPG_B2_HI        26
`define FPG_B2_LO        18
`define FPG_B1_HI        17
`define FPG_B1_LO        9
`define FPG_B0_HI        8
`define FPG_B0_LO        0

// port b width select codes {hi, lo}
`define FPG_SIZE_LONG    2'h0
`define FPG_SIZE_WORD    2'h1
`define FPG_SIZE_BYTE    2'h2
`define FPG_SIZE_MAIL    2'h3

// swap mode codes {msb, lsb}
`define FPG_SWAP_NONE    2'h0
`define FPG_SWAP_FULL    2'h1
`define FPG_SWAP_HALF    2'h2
`define FPG_SWAP_BYTE    2'h3

// last part index per read width
`define FPG_LAST_WORD    2'h1
`define FPG_LAST_BYTE    2'h3

// buffer shape
`define FPG_FIFO_DEPTH   8
`define FPG_FIFO_AW      3

// reset values
`define FPG_RST_DATA     36'h000000000
`define FPG_RST_SIZE     2'h0
`define FPG_RST_BE_N     1'h1

`endif

//--- logic/fpg_fifo.v
`timescale 1ns/1ps
module fpg_fifo #(
  parameter WIDTH = 36,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // clock and reset
  input  wire             mclk,
  input  wire             rst,
  // fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_r;
  reg [AW-1:0]    rd_ptr_r;
  reg [AW:0]      count_r;
  wire            push;
  wire            pop;
  integer         i;

  assign in_ready  = (count_r != DEPTH[AW:0]);
  assign out_valid = (count_r != {(AW+1){1'b0}});
  assign out_data  = mem_r[rd_ptr_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // pointers wrap by index, so depth must be a power of two
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r  <= {(AW+1){1'b0}};
    end else begin
      if (push)
        wr_ptr_r <= wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
      if (pop)
        rd_ptr_r <= rd_ptr_r + {{(AW-1){1'b0}}, 1'b1};
      if (push & ~pop)
        count_r <= count_r + {{AW{1'b0}}, 1'b1};
      else if (pop & ~push)
        count_r <= count_r - {{AW{1'b0}}, 1'b1};
    end
  end

  // storage has no reset, only flags do
  always @(posedge mclk) begin
    for (i = 0; i < DEPTH; i = i + 1) begin
      if (push && (wr_ptr_r == i[AW-1:0]))
        mem_r[i] <= in_data;
    end
  end

endmodule // fpg_fifo

//--- logic/fpg_core.v
// How it works
// - a high parity-generate select makes that port's reads carry generated parity
// - port a bus is four 9-bit bytes, top bit of each is parity
// - port b bus is four 9-bit bytes, top bit of each is parity
// - writes to the buffer or a mailbox store all nine bits as driven
// - generated parity comes from the low eight bits under the odd/even select
// - generated parity replaces the stored top bit, other eight bits unchanged
// - fifo parity is applied before the output register is loaded
// - for buffer reads, parity selects are sampled only on the edge loading a new long word
// - each port's checking trees also generate parity for its mailbox read
// - mailbox parity needs chip select low, enable, read, mailbox selected, generate
// - generating mailbox parity leaves the mailbox contents untouched
// - long-word swap: 00 abcd, 01 dcba, 10 cdab, 11 badc
// - word reads: big-endian upper half first on 35-18, little lower first on 17-0
// - unused half of port b keeps its last output register value
// - both width selects high route the a-to-b mailbox onto port b
// - byte reads: four reads, big-endian top byte first, little-endian low byte first
// - swap mode from the first read of a long word holds for all of it
// - port b error flag held high during a parity-generating mailbox read
`timescale 1ns/1ps
`include "fpg_regs.vh"
module fpg_core (
  // clock and reset
  input  wire        mclk,
  input  wire        rst,
  // common parity polarity, high selects odd
  input  wire        odd_even_sel,
  // port a control
  input  wire        porta_chip_sel_n,
  input  wire        porta_enable,
  input  wire        porta_write_not_read,
  input  wire        porta_mailbox_sel,
  input  wire        porta_parity_generate_sel,
  // port a data
  input  wire [35:0] porta_data_in,
  output reg  [35:0] porta_data_out,
  output reg         porta_data_oe,
  output reg         porta_parity_err_n,
  output reg         porta_fifo_full_n,
  // port b control
  input  wire        portb_chip_sel_n,
  input  wire        portb_enable,
  input  wire        portb_write_not_read,
  input  wire        portb_width_sel_lo,
  input  wire        portb_width_sel_hi,
  input  wire        big_endian_sel_n,
  input  wire        swap_mode_lsb,
  input  wire        swap_mode_msb,
  input  wire        portb_parity_generate_sel,
  // port b data
  input  wire [35:0] portb_data_in,
  output reg  [35:0] portb_data_out,
  output reg         portb_data_oe,
  output reg         portb_parity_err_n,
  output reg         portb_fifo_empty_n
);

  // per-byte xor of the eight data bits
  function [3:0] xor8s;
    input [35:0] w;
    begin
      xor8s[3] = ^w[`FPG_B3_HI-1:`FPG_B3_LO];
      xor8s[2] = ^w[`FPG_B2_HI-1:`FPG_B2_LO];
      xor8s[1] = ^w[`FPG_B1_HI-1:`FPG_B1_LO];
      xor8s[0] = ^w[`FPG_B0_HI-1:`FPG_B0_LO];
    end
  endfunction

  // the stored top bit of each byte
  function [3:0] top_bits;
    input [35:0] w;
    begin
      top_bits = {w[`FPG_B3_HI], w[`FPG_B2_HI], w[`FPG_B1_HI], w[`FPG_B0_HI]};
    end
  endfunction

  // substitute parity bits, data bits pass through
  function [35:0] put_par;
    input [35:0] w;
    input [3:0]  p;
    begin
      put_par = w;
      put_par[`FPG_B3_HI] = p[3];
      put_par[`FPG_B2_HI] = p[2];
      put_par[`FPG_B1_HI] = p[1];
      put_par[`FPG_B0_HI] = p[0];
    end
  endfunction

  // byte-order rearrangement, bits within a byte stay put
  function [35:0] swap36;
    input [35:0] w;
    input [1:0]  mode;
    reg   [8:0]  ba;
    reg   [8:0]  bb;
    reg   [8:0]  bc;
    reg   [8:0]  bd;
    begin
      ba = w[`FPG_B3_HI:`FPG_B3_LO];
      bb = w[`FPG_B2_HI:`FPG_B2_LO];
      bc = w[`FPG_B1_HI:`FPG_B1_LO];
      bd = w[`FPG_B0_HI:`FPG_B0_LO];
      case (mode)
        `FPG_SWAP_NONE: swap36 = {ba, bb, bc, bd};
        `FPG_SWAP_FULL: swap36 = {bd, bc, bb, ba};
        `FPG_SWAP_HALF: swap36 = {bc, bd, ba, bb};
        `FPG_SWAP_BYTE: swap36 = {bb, ba, bd, bc};
        default:        swap36 = w;
      endcase
    end
  endfunction

  // decoded port activity
  wire        a_sel;
  wire        a_wr;
  wire        a_rd;
  wire        a_mail_gen;
  wire        b_sel;
  wire        b_wr;
  wire        b_rd;
  wire [1:0]  b_size_live;
  wire        b_mail;
  wire        b_mail_gen;
  wire        b_fifo_rd;

  assign a_sel       = ~porta_chip_sel_n & porta_enable;
  assign a_wr        = a_sel & porta_write_not_read;
  assign a_rd        = a_sel & ~porta_write_not_read;
  assign b_sel       = ~portb_chip_sel_n & portb_enable;
  assign b_wr        = b_sel & portb_write_not_read;
  assign b_rd        = b_sel & ~portb_write_not_read;
  assign b_size_live = {portb_width_sel_hi, portb_width_sel_lo};
  assign b_mail      = (b_size_live == `FPG_SIZE_MAIL);
  assign b_fifo_rd   = b_rd & ~b_mail;
  assign a_mail_gen  = a_rd & porta_mailbox_sel & porta_parity_generate_sel;
  assign b_mail_gen  = b_rd & b_mail & portb_parity_generate_sel;

  // mailbox storage
  reg  [35:0] mailbox_a_to_b_r;
  reg  [35:0] mailbox_b_to_a_r;

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      mailbox_a_to_b_r <= `FPG_RST_DATA;
      mailbox_b_to_a_r <= `FPG_RST_DATA;
    end else begin
      if (a_wr & porta_mailbox_sel)
        mailbox_a_to_b_r <= porta_data_in;
      if (b_wr & b_mail)
        mailbox_b_to_a_r <= portb_data_in;
    end
  end

  // long-word buffer between the ports
  wire        buf_in_ready;
  wire        buf_out_valid;
  wire [35:0] buf_out_data;
  wire        buf_pop;

  fpg_fifo #(
    .WIDTH (`FPG_DATA_W),
    .DEPTH (`FPG_FIFO_DEPTH),
    .AW    (`FPG_FIFO_AW)
  ) u_buf (
    .mclk      (mclk),
    .rst       (rst),
    .in_valid  (a_wr & ~porta_mailbox_sel),
    .in_ready  (buf_in_ready),
    .in_data   (porta_data_in),
    .out_valid (buf_out_valid),
    .out_ready (buf_pop),
    .out_data  (buf_out_data)
  );

  // shared trees: each port checks its bus or generates for its mailbox
  wire [35:0] tree_a_in;
  wire [35:0] tree_b_in;
  wire [3:0]  tree_a_x;
  wire [3:0]  tree_b_x;
  wire [3:0]  gen_a;
  wire [3:0]  gen_b;
  wire [3:0]  bad_a;
  wire [3:0]  bad_b;

  assign tree_a_in = a_mail_gen ? mailbox_b_to_a_r : porta_data_in;
  assign tree_b_in = b_mail_gen ? mailbox_a_to_b_r : portb_data_in;
  assign tree_a_x  = xor8s(tree_a_in);
  assign tree_b_x  = xor8s(tree_b_in);
  assign gen_a     = tree_a_x ^ {4{odd_even_sel}};
  assign gen_b     = tree_b_x ^ {4{odd_even_sel}};
  assign bad_a     = tree_a_x ^ top_bits(tree_a_in) ^ {4{odd_even_sel}};
  assign bad_b     = tree_b_x ^ top_bits(tree_b_in) ^ {4{odd_even_sel}};

  // port b size and endian selections, held across mailbox access
  reg  [1:0]  size_q_r;
  reg         be_q_n_r;

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      size_q_r <= `FPG_RST_SIZE;
      be_q_n_r <= `FPG_RST_BE_N;
    end else if (!b_mail) begin
      size_q_r <= b_size_live;
      be_q_n_r <= big_endian_sel_n;
    end
  end

  // long-word unpacking state
  reg  [35:0] aux_r;
  reg  [1:0]  part_r;
  reg         pend_r;
  reg  [1:0]  ld_size_r;
  reg  [35:0] fifo_out_r;
  reg  [35:0] aux_nxt;
  reg  [1:0]  part_nxt;
  reg         pend_nxt;
  reg  [1:0]  ld_size_nxt;
  reg  [35:0] fifo_out_nxt;
  reg  [35:0] src;
  reg  [1:0]  idx;
  reg  [1:0]  last;
  wire        new_lw;
  wire [35:0] fifo_gen;

  // a size change abandons whatever parts were still pending
  assign new_lw  = ~pend_r | (size_q_r != ld_size_r);
  assign buf_pop = b_fifo_rd & new_lw & buf_out_valid;
  assign fifo_gen = portb_parity_generate_sel ?
                    put_par(buf_out_data, xor8s(buf_out_data) ^ {4{odd_even_sel}}) :
                    buf_out_data;

  always @* begin
    aux_nxt      = aux_r;
    part_nxt     = part_r;
    pend_nxt     = pend_r;
    ld_size_nxt  = ld_size_r;
    fifo_out_nxt = fifo_out_r;
    src          = aux_r;
    idx          = part_r;
    last         = 2'h0;
    if (b_fifo_rd && (!new_lw || buf_out_valid)) begin
      if (new_lw) begin
        // selects taken on the load edge
        // swap fixed for the long word
        src         = swap36(fifo_gen, {swap_mode_msb, swap_mode_lsb});
        idx         = 2'h0;
        aux_nxt     = src;
        ld_size_nxt = size_q_r;
      end
      case (size_q_r)
        `FPG_SIZE_WORD: last = `FPG_LAST_WORD;
        `FPG_SIZE_BYTE: last = `FPG_LAST_BYTE;
        default:        last = 2'h0;
      endcase
      pend_nxt = (idx != last);
      part_nxt = idx + 2'h1;
      case (size_q_r)
        `FPG_SIZE_LONG: begin
          fifo_out_nxt = src;
        end
        `FPG_SIZE_WORD: begin
          if (!be_q_n_r) begin
            if (idx == 2'h0)
              fifo_out_nxt[35:18] = src[35:18];
            else
              fifo_out_nxt[35:18] = src[17:0];
          end else begin
            if (idx == 2'h0)
              fifo_out_nxt[17:0] = src[17:0];
            else
              fifo_out_nxt[17:0] = src[35:18];
          end
        end
        `FPG_SIZE_BYTE: begin
          if (!be_q_n_r) begin
            case (idx)
              2'h0:    fifo_out_nxt[35:27] = src[35:27];
              2'h1:    fifo_out_nxt[35:27] = src[26:18];
              2'h2:    fifo_out_nxt[35:27] = src[17:9];
              default: fifo_out_nxt[35:27] = src[8:0];
            endcase
          end else begin
            case (idx)
              2'h0:    fifo_out_nxt[8:0] = src[8:0];
              2'h1:    fifo_out_nxt[8:0] = src[17:9];
              2'h2:    fifo_out_nxt[8:0] = src[26:18];
              default: fifo_out_nxt[8:0] = src[35:27];
            endcase
          end
        end
        default: begin
          fifo_out_nxt = fifo_out_r;
        end
      endcase
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      aux_r      <= `FPG_RST_DATA;
      part_r     <= 2'h0;
      pend_r     <= 1'b0;
      ld_size_r  <= `FPG_RST_SIZE;
      fifo_out_r <= `FPG_RST_DATA;
    end else begin
      aux_r      <= aux_nxt;
      part_r     <= part_nxt;
      pend_r     <= pend_nxt;
      ld_size_r  <= ld_size_nxt;
      fifo_out_r <= fifo_out_nxt;
    end
  end

  // valid port b bytes for checking under the implemented size
  reg  [3:0]  b_valid_bytes;

  always @* begin
    case (size_q_r)
      `FPG_SIZE_WORD: b_valid_bytes = be_q_n_r ? 4'h3 : 4'hc;
      `FPG_SIZE_BYTE: b_valid_bytes = be_q_n_r ? 4'h1 : 4'h8;
      default:        b_valid_bytes = 4'hf;
    endcase
  end

  // port outputs, all registered
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      porta_data_out     <= `FPG_RST_DATA;
      porta_data_oe      <= 1'b0;
      porta_parity_err_n <= 1'b1;
      porta_fifo_full_n  <= 1'b1;
      portb_data_out     <= `FPG_RST_DATA;
      portb_data_oe      <= 1'b0;
      portb_parity_err_n <= 1'b1;
      portb_fifo_empty_n <= 1'b0;
    end else begin
      porta_data_oe <= ~porta_chip_sel_n & ~porta_write_not_read;
      if (a_rd & porta_mailbox_sel) begin
        if (porta_parity_generate_sel)
          porta_data_out <= put_par(mailbox_b_to_a_r, gen_a);
        else
          porta_data_out <= mailbox_b_to_a_r;
      end
      porta_parity_err_n <= a_mail_gen ? 1'b1 : ~(|bad_a);
      // flags lag one edge, the buffer itself refuses writes when full
      porta_fifo_full_n  <= buf_in_ready;
      portb_fifo_empty_n <= buf_out_valid;
      portb_data_oe      <= ~portb_chip_sel_n & ~portb_write_not_read;
      if (b_mail) begin
        if (b_rd) begin
          if (portb_parity_generate_sel)
            portb_data_out <= put_par(mailbox_a_to_b_r, gen_b);
          else
            portb_data_out <= mailbox_a_to_b_r;
        end
      end else begin
        portb_data_out <= fifo_out_nxt;
      end
      portb_parity_err_n <= b_mail_gen ? 1'b1 : ~(|(bad_b & b_valid_bytes));
    end
  end

endmodule // fpg_core

//--- tb/fpg_core_sva.sv
`timescale 1ns/1ps
`include "fpg_regs.vh"
module fpg_core_sva (
  // clock, reset and parity polarity
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        odd_even_sel,
  // port a
  input wire logic        porta_chip_sel_n,
  input wire logic        porta_enable,
  input wire logic        porta_write_not_read,
  input wire logic        porta_mailbox_sel,
  input wire logic        porta_parity_generate_sel,
  input wire logic [35:0] porta_data_in,
  input wire logic [35:0] porta_data_out,
  input wire logic        porta_parity_err_n,
  // port b
  input wire logic        portb_chip_sel_n,
  input wire logic        portb_enable,
  input wire logic        portb_write_not_read,
  input wire logic        portb_width_sel_lo,
  input wire logic        portb_width_sel_hi,
  input wire logic        big_endian_sel_n,
  input wire logic        portb_parity_generate_sel,
  input wire logic [35:0] portb_data_in,
  input wire logic [35:0] portb_data_out,
  input wire logic        portb_parity_err_n
);
  localparam logic [35:0] LOW8 = 36'h7fbfdfeff;
  logic [35:0] mb_ab_r;
  logic [35:0] mb_ba_r;
  wire       acc_a = !porta_chip_sel_n && porta_enable;
  wire       acc_b = !portb_chip_sel_n && portb_enable;
  wire [1:0] wsel  = {portb_width_sel_hi, portb_width_sel_lo};
  wire       wr_ab = acc_a && porta_write_not_read && porta_mailbox_sel;
  wire       wr_ba = acc_b && portb_write_not_read && wsel == `FPG_SIZE_MAIL;
  wire       rd_a  = acc_a && !porta_write_not_read && porta_mailbox_sel;
  wire       rd_b  = acc_b && !portb_write_not_read;
  // shadow mailboxes, all nine bits per byte as driven
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mb_ab_r <= 36'h0;
      mb_ba_r <= 36'h0;
    end else begin
      if (wr_ab) mb_ab_r <= porta_data_in;
      if (wr_ba) mb_ba_r <= portb_data_in;
    end
  end
  function automatic logic par_ok(input logic [35:0] w, input logic odd);
    par_ok = 1'b1;
    for (int i = 0; i < 4; i++) if (w[9*i+8] != (^w[9*i+:8] ^ odd)) par_ok = 1'b0;
  endfunction
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // same-edge writes excluded: read-during-write order is left open
  sequence s_mrd_a; rd_a && !wr_ba; endsequence
  sequence s_mrd_b; rd_b && wsel == `FPG_SIZE_MAIL && !wr_ab; endsequence
  sequence s_part(sz, lvl);
    rd_b && wsel == sz && $past(wsel) == sz && $past(big_endian_sel_n) == lvl;
  endsequence
  property p_gen_a; s_mrd_a ##0 porta_parity_generate_sel |=>
    par_ok(porta_data_out, $past(odd_even_sel)); endproperty
  a_gen_a: assert property (p_gen_a) else $error("port a mailbox parity wrong");
  property p_gen_b; s_mrd_b ##0 portb_parity_generate_sel |=>
    par_ok(portb_data_out, $past(odd_even_sel)); endproperty
  a_gen_b: assert property (p_gen_b) else $error("port b mailbox parity wrong");
  property p_err_a; s_mrd_a ##0 porta_parity_generate_sel |=> porta_parity_err_n; endproperty
  a_err_a: assert property (p_err_a) else $error("port a error flag not held");
  property p_err_b; s_mrd_b ##0 portb_parity_generate_sel |=> portb_parity_err_n; endproperty
  a_err_b: assert property (p_err_b) else $error("port b error flag not held");
  property p_mb_a; s_mrd_a |=> ((porta_data_out ^ $past(mb_ba_r)) &
    ($past(porta_parity_generate_sel) ? LOW8 : '1)) == 36'h0; endproperty
  a_mb_a: assert property (p_mb_a) else $error("port a mailbox data wrong");
  property p_mb_b; s_mrd_b |=> ((portb_data_out ^ $past(mb_ab_r)) &
    ($past(portb_parity_generate_sel) ? LOW8 : '1)) == 36'h0; endproperty
  a_mb_b: assert property (p_mb_b) else $error("port b mailbox data wrong");
  property p_wbig; s_part(`FPG_SIZE_WORD, 1'b0) |=> $stable(portb_data_out[17:0]); endproperty
  a_wbig: assert property (p_wbig) else $error("unused low half changed");
  property p_wlit; s_part(`FPG_SIZE_WORD, 1'b1) |=> $stable(portb_data_out[35:18]); endproperty
  a_wlit: assert property (p_wlit) else $error("unused high half changed");
  property p_bbig; s_part(`FPG_SIZE_BYTE, 1'b0) |=> $stable(portb_data_out[26:0]); endproperty
  a_bbig: assert property (p_bbig) else $error("unused bytes changed");
endmodule // fpg_core_sva

bind fpg_core fpg_core_sva u_sva (.*);

//--- tb/fpg_host.sv
`timescale 1ns/1ps
module fpg_host (
  // clock
  input wire logic         mclk,
  // port a bus
  input wire logic [35:0]  porta_data_out,
  input wire logic         porta_data_oe,
  output wire logic [35:0] porta_data_in,
  // port a control
  output logic             porta_chip_sel_n,
  output logic             porta_enable,
  output logic             porta_write_not_read,
  output logic             porta_mailbox_sel,
  output logic             porta_parity_generate_sel
);
  logic [35:0] drv_r = 36'h0;
  assign porta_data_in = porta_data_oe ? porta_data_out : drv_r;
  initial begin
    porta_chip_sel_n = 1'b1;
    porta_enable = 1'b0;
    porta_write_not_read = 1'b0;
    porta_mailbox_sel = 1'b0;
    porta_parity_generate_sel = 1'b0;
  end
  task automatic awr(input logic mb, input logic [35:0] d);
    @(posedge mclk);
    porta_chip_sel_n <= 1'b0;
    porta_enable <= 1'b1;
    porta_write_not_read <= 1'b1;
    porta_mailbox_sel <= mb;
    drv_r <= d;
    @(posedge mclk);
    porta_chip_sel_n <= 1'b1;
    porta_enable <= 1'b0;
    // released bus shows the inverse, not a stale copy
    drv_r <= ~d;
  endtask
  task automatic ard(input logic pg, output logic [35:0] q);
    @(posedge mclk);
    porta_chip_sel_n <= 1'b0;
    porta_enable <= 1'b1;
    porta_write_not_read <= 1'b0;
    porta_mailbox_sel <= 1'b1;
    porta_parity_generate_sel <= pg;
    @(posedge mclk);
    porta_chip_sel_n <= 1'b1;
    porta_enable <= 1'b0;
    #1 q = porta_data_out;
  endtask
endmodule // fpg_host

//--- tb/fifo_read_parity_gen_and_swap_bench.sv
`timescale 1ns/1ps
`include "fpg_regs.vh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module fifo_read_parity_gen_and_swap_bench;
  logic        mclk, rst, odd_even_sel;
  logic        porta_chip_sel_n, porta_enable, porta_write_not_read, porta_mailbox_sel;
  logic        porta_parity_generate_sel, porta_data_oe, porta_parity_err_n, porta_fifo_full_n;
  logic [35:0] porta_data_in, porta_data_out, portb_data_out, b_drv, q, p, e;
  logic        portb_chip_sel_n, portb_enable, portb_write_not_read, portb_width_sel_lo;
  logic        portb_width_sel_hi, big_endian_sel_n, swap_mode_lsb, swap_mode_msb;
  logic        portb_parity_generate_sel, portb_data_oe, portb_parity_err_n, portb_fifo_empty_n;
  wire  [35:0] portb_data_in = portb_data_oe ? portb_data_out : b_drv;
  int          miscompares, samples_checked;
  fpg_core uut (.*);
  fpg_host host (.*);
  always #5 mclk = ~mclk;
  function automatic logic [35:0] wv(input int i);
    wv = 36'h9a5c3e1f7 + 36'(i) * 36'h102030405;
  endfunction
  function automatic logic [35:0] swp(input logic [35:0] w, input logic [1:0] m);
    case (m)
      2'h0: swp = w;
      2'h1: swp = {w[8:0], w[17:9], w[26:18], w[35:27]};
      2'h2: swp = {w[17:0], w[35:18]};
      default: swp = {w[26:18], w[35:27], w[8:0], w[17:9]};
    endcase
  endfunction
  function automatic logic [35:0] gen(input logic [35:0] w, input logic odd);
    gen = w;
    for (int i = 0; i < 4; i++) gen[9*i+8] = ^w[9*i+:8] ^ odd;
  endfunction
  // width set one edge ahead so the stored size is in place at the read
  task automatic brd(input logic [1:0] sz, input logic bn, input logic [1:0] sw,
                     input logic pg, output logic [35:0] r);
    @(posedge mclk);
    {portb_width_sel_hi, portb_width_sel_lo} <= sz;
    big_endian_sel_n <= bn;
    {swap_mode_msb, swap_mode_lsb} <= sw;
    portb_parity_generate_sel <= pg;
    @(posedge mclk);
    portb_chip_sel_n <= 1'b0;
    portb_enable <= 1'b1;
    portb_write_not_read <= 1'b0;
    @(posedge mclk);
    portb_chip_sel_n <= 1'b1;
    portb_enable <= 1'b0;
    #1 r = portb_data_out;
  endtask
  task automatic bwr(input logic [35:0] d);
    @(posedge mclk);
    {portb_width_sel_hi, portb_width_sel_lo} <= `FPG_SIZE_MAIL;
    portb_chip_sel_n <= 1'b0;
    portb_enable <= 1'b1;
    portb_write_not_read <= 1'b1;
    b_drv <= d;
    @(posedge mclk);
    portb_chip_sel_n <= 1'b1;
    portb_enable <= 1'b0;
    b_drv <= ~d;
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #50000;
    miscompares++;
    conclude();
  end
  initial begin
    {mclk, odd_even_sel, portb_enable, portb_write_not_read} = 4'h8;
    {rst, portb_chip_sel_n, big_endian_sel_n} = 3'h7;
    {portb_width_sel_hi, portb_width_sel_lo, swap_mode_msb, swap_mode_lsb} = 4'h0;
    {portb_parity_generate_sel, b_drv, miscompares, samples_checked} = 0;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1 `CHK({portb_data_out, porta_data_oe, porta_fifo_full_n, portb_fifo_empty_n}, 39'h2)
    for (int m = 0; m < 4; m++) host.awr(1'b0, wv(m));
    repeat (2) @(posedge mclk);
    for (int m = 0; m < 4; m++) begin
      brd(`FPG_SIZE_LONG, 1'b1, 2'(m), 1'b0, q);
      `CHK(q, swp(wv(m), 2'(m)))
    end
    for (int o = 0; o < 2; o++) begin
      @(posedge mclk) odd_even_sel <= o[0];
      host.awr(1'b0, wv(o + 4));
      repeat (2) @(posedge mclk);
      brd(`FPG_SIZE_LONG, 1'b1, 2'h0, 1'b1, q);
      `CHK(q, gen(wv(o + 4), o[0]))
    end
    host.awr(1'b0, wv(6));
    host.awr(1'b0, wv(7));
    repeat (2) @(posedge mclk);
    e = gen(swp(wv(6), 2'h1), 1'b1);
    brd(`FPG_SIZE_WORD, 1'b0, 2'h1, 1'b1, q);
    `CHK(q[35:18], e[35:18])
    p = q;
    brd(`FPG_SIZE_WORD, 1'b0, 2'h2, 1'b0, q);
    `CHK(q, {e[17:0], p[17:0]})
    e = swp(wv(7), 2'h3);
    brd(`FPG_SIZE_WORD, 1'b1, 2'h3, 1'b0, q);
    `CHK(q[17:0], e[17:0])
    p = q;
    brd(`FPG_SIZE_WORD, 1'b1, 2'h0, 1'b0, q);
    `CHK(q, {p[35:18], e[35:18]})
    for (int b = 0; b < 2; b++) begin
      host.awr(1'b0, wv(8 + b));
      repeat (2) @(posedge mclk);
      e = swp(wv(8 + b), b ? 2'h1 : 2'h2);
      for (int k = 0; k < 4; k++) begin
        brd(`FPG_SIZE_BYTE, b[0], k ? 2'(k) : (b ? 2'h1 : 2'h2), 1'b0, q);
        `CHK(b ? q[8:0] : q[35:27], b ? e[9*k+:9] : e[35-9*k-:9])
      end
    end
    host.awr(1'b1, wv(10));
    brd(`FPG_SIZE_MAIL, 1'b1, 2'h0, 1'b1, q);
    `CHK({q, portb_parity_err_n, portb_data_oe}, {gen(wv(10), 1'b1), 2'h3})
    brd(`FPG_SIZE_MAIL, 1'b1, 2'h0, 1'b0, q);
    `CHK(q, wv(10))
    // idle bus is all zeros, so odd checking must flag the valid low byte
    `CHK(portb_parity_err_n, 1'b0)
    bwr(wv(11));
    host.ard(1'b1, q);
    `CHK({q, porta_parity_err_n}, {gen(wv(11), 1'b1), 1'b1})
    host.ard(1'b0, q);
    `CHK(q, wv(11))
    `CHK(porta_data_oe, 1'b1)
    for (int i = 0; i < 9; i++) host.awr(1'b0, wv(12 + i));
    repeat (2) @(posedge mclk);
    #1 `CHK(porta_fifo_full_n, 1'b0)
    for (int i = 0; i < 9; i++) begin
      brd(`FPG_SIZE_LONG, 1'b1, 2'h0, 1'b0, q);
      `CHK(q, wv(12 + (i < 8 ? i : 7)))
    end
    `CHK(portb_fifo_empty_n, 1'b0)
    conclude();
  end
endmodule // fifo_read_parity_gen_and_swap_bench
